/* src/slc_pkg.sv */
/*
  Constants for the sleep mode controller: register map, field layout,
  mode encodings and wake timing.
  Assumes a 200 MHz peripheral clock and a 32-bit AXI4-Lite register bus.
*/
package slc_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0]  SLC_SLEEP_CONTROL_OFS = 8'h00;
    localparam logic [7:0]  SLC_STATUS_OFS        = 8'h04;
    localparam logic [7:0]  SLC_WAKE_ENABLE_OFS   = 8'h08;
    localparam logic [7:0]  SLC_RUN_STANDBY_OFS   = 8'h0C;
    localparam logic [7:0]  SLC_SLEEP_CONTROL_RST = 8'h00;
    localparam logic [8:0]  SLC_WAKE_ENABLE_RST   = 9'h000;
    localparam logic [3:0]  SLC_RUN_STANDBY_RST   = 4'h0;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int SLC_SEN_BIT      = 0;
    localparam int SLC_SLEEP_MODE_SELECT_LSB    = 1;
    localparam int SLC_SLEEP_MODE_SELECT_MSB    = 2;
    localparam int SLC_CTRL_MSB     = 2;

    // run_in_standby bits
    localparam int SLC_RS_RTC       = 0;
    localparam int SLC_RS_ADC       = 1;
    localparam int SLC_RS_UART      = 2;
    localparam int SLC_RS_MAINOSC   = 3;

    // wake source indices
    localparam int SLC_WK_PIN       = 0;
    localparam int SLC_WK_TWI       = 1;
    localparam int SLC_WK_PIT       = 2;
    localparam int SLC_WK_UART      = 3;
    localparam int SLC_WK_ADC       = 4;
    localparam int SLC_WK_RTC       = 5;
    localparam int SLC_WK_TIMER_B   = 6;
    localparam int SLC_WK_OTHER     = 7;
    localparam int SLC_WK_SPARE     = 8;
    localparam int SLC_WK_N         = 9;

    // ------------------------------------------------------------
    // modes and states
    // ------------------------------------------------------------
    localparam logic [1:0]  SLC_MODE_IDLE     = 2'h0;
    localparam logic [1:0]  SLC_MODE_STANDBY  = 2'h1;
    localparam logic [1:0]  SLC_MODE_POWER_DOWN_MODE    = 2'h2;
    localparam logic [1:0]  SLC_BOD_WAIT_MODE = 2'h3;

    typedef enum logic [1:0] {
        SLC_ACTIVE,
        SLC_ASLEEP,
        SLC_WAKING
    } slc_state_t;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int          SLC_WAKE_CYCLES = 6;
    localparam logic [2:0]  SLC_WAKE_CNT    = 3'(SLC_WAKE_CYCLES - 1);

    localparam logic [1:0]  SLC_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  SLC_RESP_SLVERR = 2'h2;

endpackage : slc_pkg

/* src/slc_sleep_controller.sv */
/*
  Sleep mode controller: active, idle, standby and power-down sequencing,
  clock domain gating, wake source selection and wake delay.
  Assumes the cpu pulses sleep_instr when it runs the sleep instruction,
  oscillator start-up is reported by osc_ready and the clock controller
  honours the gate outputs. aresetn covers every device reset source.
*/
// Overview of operation
// [RL1] sleep needs enable, mode and sleep instruction
// [RL2] sleep halts cpu, gates mode's clock domains
// [RL3] permitted interrupt wakes, cpu resumes after sleep
// [RL4] any reset returns controller to active
// [RL5] debug break forces wake without interrupt
// [RL6] no enabled interrupt means sleep until reset
// [RL7] idle stops cpu clock only, all sources wake
// [RL8] standby peripherals follow their run_in_standby
// [RL9] standby wake: pin, twi, timer_b, gated others
// [RL10] power down keeps only watchdog and pit
// [RL11] power down wake: pin change, twi match
// [RL12] standby clocks kept only with run_in_standby; code keeps pit and watchdog clocks on regardless
// [RL13] resume six cycles after wake plus osc start
// [RL14] idle adds no oscillator start-up time
// [RL15] power down: only ulp and rtc clock optional
// [RL16] bod mode 0x3 waits for detector ready
// [RL17] control register holds mode and enable
// [RL18] mode codes: idle, standby, power down, reserved
// [RL19] software sets enable before sleep instruction
// [RL20] reserved mode sleep request is a no-op
`timescale 1ns/10ps
`default_nettype none

module slc_sleep_controller
    import slc_pkg::*;
(
    // clock and reset
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire logic                 clk_en,
    // axi4-lite write
    input  wire logic [7:0]           s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]           s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    // cpu and debug
    input  wire logic                 sleep_instr,
    input  wire logic                 debug_break,
    output logic                      cpu_halt,
    output logic                      cpu_resume,
    // wake sources and system status
    input  wire logic [SLC_WK_N-1:0]  irq_pending,
    input  wire logic                 osc_ready,
    input  wire logic [1:0]           bod_active_mode_field,
    input  wire logic                 bod_ready,
    input  wire logic                 bod_uses_ulp,
    input  wire logic                 watchdog_uses_ulp,
    // clock gates, high means running; sleep_mode reports the sleep mode
    output logic                      cpu_clk_on,
    output logic                      per_clk_on,
    output logic                      rtc_clk_on,
    output logic                      adc_clk_on,
    output logic                      pit_clk_on,
    output logic                      watchdog_clk_on,
    output logic                      main_osc_on,
    output logic                      rtc_osc_on,
    output logic                      ulp_osc_on,
    output logic                      uart_on,
    output logic [1:0]                sleep_mode
);

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [SLC_CTRL_MSB:0]  sleep_control_reg;
    logic [SLC_WK_N-1:0]    wake_enable_reg;
    logic [3:0]             run_in_standby_reg;
    logic [1:0]             mode_reg;
    logic [2:0]             wait_cnt_reg;
    logic                   need_osc_reg;
    slc_state_t             state_reg;

    logic                   aw_hold_reg;
    logic                   w_hold_reg;
    logic [7:0]             awaddr_reg;
    logic [31:0]            wdata_reg;
    logic                   wstrb0_reg;

    logic [1:0]             sleep_mode_select;
    logic                   sleep_ok;
    logic [SLC_WK_N-1:0]    allowed;
    logic                   wake_evt;
    logic                   osc_ok;
    logic                   bod_ok;
    logic                   wr_fire;

    assign sleep_mode_select = sleep_control_reg[SLC_SLEEP_MODE_SELECT_MSB:SLC_SLEEP_MODE_SELECT_LSB];

    // ------------------------------------------------------------
    // axi4-lite slave
    // ------------------------------------------------------------
    assign s_axi_awready = !aw_hold_reg && !s_axi_bvalid;
    assign s_axi_wready  = !w_hold_reg && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_fire       = aw_hold_reg && w_hold_reg && !s_axi_bvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold_reg  <= 1'b0;
            w_hold_reg   <= 1'b0;
            awaddr_reg   <= 8'h00;
            wdata_reg    <= 32'h00000000;
            wstrb0_reg   <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= SLC_RESP_OKAY;
        end
        else if (clk_en)
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_hold_reg <= 1'b1;
                awaddr_reg  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_hold_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata;
                wstrb0_reg <= s_axi_wstrb[0] | s_axi_wstrb[1];
            end
            if (wr_fire)
            begin
                aw_hold_reg  <= 1'b0;
                w_hold_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (awaddr_reg[7:2] <= SLC_RUN_STANDBY_OFS[7:2])
                                ? SLC_RESP_OKAY : SLC_RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // register writes; lane 0 or lane 1 enables a write to any register
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sleep_control_reg  <= SLC_SLEEP_CONTROL_RST[SLC_CTRL_MSB:0]; // RL4
            wake_enable_reg    <= SLC_WAKE_ENABLE_RST;
            run_in_standby_reg <= SLC_RUN_STANDBY_RST;
        end
        else if (clk_en && wr_fire && wstrb0_reg)
        begin
            unique case (awaddr_reg)
                SLC_SLEEP_CONTROL_OFS: sleep_control_reg  <= wdata_reg[SLC_CTRL_MSB:0]; // RL17
                SLC_WAKE_ENABLE_OFS:   wake_enable_reg    <= wdata_reg[SLC_WK_N-1:0];
                SLC_RUN_STANDBY_OFS:   run_in_standby_reg <= wdata_reg[3:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= SLC_RESP_OKAY;
        end
        else if (clk_en)
        begin
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= SLC_RESP_OKAY;
                unique case (s_axi_araddr)
                    SLC_SLEEP_CONTROL_OFS: s_axi_rdata <= {29'h0, sleep_control_reg};
                    SLC_STATUS_OFS:        s_axi_rdata <= {28'h0, mode_reg, state_reg};
                    SLC_WAKE_ENABLE_OFS:   s_axi_rdata <= {23'h0, wake_enable_reg};
                    SLC_RUN_STANDBY_OFS:   s_axi_rdata <= {28'h0, run_in_standby_reg};
                    default:
                    begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= SLC_RESP_SLVERR;
                    end
                endcase
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // wake source selection
    // ------------------------------------------------------------
    always_comb
    begin
        allowed = '0;
        unique case (mode_reg)
            SLC_MODE_IDLE: allowed = '1; // RL7
            SLC_MODE_STANDBY:
            begin
                allowed[SLC_WK_PIN]     = 1'b1; // RL9
                allowed[SLC_WK_TWI]     = 1'b1;
                allowed[SLC_WK_PIT]     = 1'b1;
                allowed[SLC_WK_TIMER_B] = 1'b1;
                allowed[SLC_WK_UART]    = run_in_standby_reg[SLC_RS_UART];
                allowed[SLC_WK_ADC]     = run_in_standby_reg[SLC_RS_ADC];
                allowed[SLC_WK_RTC]     = run_in_standby_reg[SLC_RS_RTC];
            end
            SLC_MODE_POWER_DOWN_MODE:
            begin
                allowed[SLC_WK_PIN] = 1'b1; // RL11
                allowed[SLC_WK_TWI] = 1'b1;
                allowed[SLC_WK_PIT] = 1'b1;
            end
            default: allowed = '0;
        endcase
    end

    // with no enabled source only reset or a debug break ends sleep
    assign wake_evt = |(irq_pending & wake_enable_reg & allowed) || debug_break; // RL3 RL5 RL6

    // the main oscillator runs through idle, so only deeper modes wait on it
    assign osc_ok = !need_osc_reg || osc_ready; // RL14
    assign bod_ok = (bod_active_mode_field != SLC_BOD_WAIT_MODE) || bod_ready; // RL16

    // sleep_enable_bit must be set by software before the instruction
    assign sleep_ok = sleep_instr && sleep_control_reg[SLC_SEN_BIT]
                      && (sleep_mode_select != SLC_BOD_WAIT_MODE); // RL1 RL19 RL20

    // ------------------------------------------------------------
    // sleep sequencer
    // ------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_reg    <= SLC_ACTIVE; // RL4
            mode_reg     <= SLC_MODE_IDLE;
            wait_cnt_reg <= 3'h0;
            need_osc_reg <= 1'b0;
            cpu_resume   <= 1'b0;
        end
        else if (clk_en)
        begin
            cpu_resume <= 1'b0;
            unique case (state_reg)
                SLC_ACTIVE:
                    if (sleep_ok)
                    begin
                        state_reg <= SLC_ASLEEP; // RL1
                        mode_reg  <= sleep_mode_select; // RL18
                        need_osc_reg <= (sleep_mode_select == SLC_MODE_POWER_DOWN_MODE) ||
                                        !run_in_standby_reg[SLC_RS_MAINOSC];
                    end
                SLC_ASLEEP:
                    if (wake_evt)
                    begin
                        state_reg    <= SLC_WAKING;
                        wait_cnt_reg <= SLC_WAKE_CNT; // RL13
                        if (mode_reg == SLC_MODE_IDLE)
                            need_osc_reg <= 1'b0;
                    end
                SLC_WAKING:
                    if (wait_cnt_reg != 3'h0)
                        wait_cnt_reg <= wait_cnt_reg - 3'h1;
                    else if (osc_ok && bod_ok)
                    begin
                        state_reg  <= SLC_ACTIVE; // RL13 RL16
                        cpu_resume <= 1'b1; // RL3
                    end
                default: state_reg <= SLC_ACTIVE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // clock domain gating
    // ------------------------------------------------------------
    logic asleep;
    logic sb;
    logic pd;

    assign asleep = (state_reg != SLC_ACTIVE);
    assign sb     = asleep && (mode_reg == SLC_MODE_STANDBY);
    assign pd     = asleep && (mode_reg == SLC_MODE_POWER_DOWN_MODE);

    // waking keeps the main oscillator requested so the delay can run
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cpu_halt        <= 1'b0;
            cpu_clk_on      <= 1'b1;
            per_clk_on      <= 1'b1;
            rtc_clk_on      <= 1'b1;
            adc_clk_on      <= 1'b1;
            pit_clk_on      <= 1'b1;
            watchdog_clk_on <= 1'b1;
            main_osc_on     <= 1'b1;
            rtc_osc_on      <= 1'b1;
            ulp_osc_on      <= 1'b1;
            uart_on         <= 1'b1;
            sleep_mode      <= SLC_MODE_IDLE;
        end
        else if (clk_en)
        begin
            cpu_halt        <= asleep; // RL2
            cpu_clk_on      <= !asleep; // RL7
            per_clk_on      <= !(sb || pd); // RL8 RL10
            rtc_clk_on      <= !pd && (!sb || run_in_standby_reg[SLC_RS_RTC]); // RL12
            adc_clk_on      <= !pd && (!sb || run_in_standby_reg[SLC_RS_ADC]); // RL12
            uart_on         <= !pd && (!sb || run_in_standby_reg[SLC_RS_UART]); // RL8
            pit_clk_on      <= 1'b1; // RL10
            watchdog_clk_on <= 1'b1; // RL10
            main_osc_on     <= (state_reg == SLC_WAKING) ||
                               (!pd && (!sb || run_in_standby_reg[SLC_RS_MAINOSC])); // RL12
            rtc_osc_on      <= !pd ? (!sb || run_in_standby_reg[SLC_RS_RTC])
                                   : (bod_uses_ulp || watchdog_uses_ulp); // RL15
            ulp_osc_on      <= !pd || bod_uses_ulp || watchdog_uses_ulp; // RL15
            sleep_mode      <= mode_reg;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_sleep_needs_enable: assert property (@(posedge aclk) disable iff (!aresetn) // RL1
        (state_reg == SLC_ACTIVE && clk_en && !sleep_ok) |=> state_reg == SLC_ACTIVE)
        else $error("sleep entered without enable");

    chk_reserved_noop: assert property (@(posedge aclk) disable iff (!aresetn) // RL20
        (state_reg == SLC_ACTIVE && sleep_mode_select == SLC_BOD_WAIT_MODE) |=> state_reg == SLC_ACTIVE)
        else $error("reserved mode entered sleep");

    chk_halt_follows: assert property (@(posedge aclk) disable iff (!aresetn) // RL2
        (clk_en && asleep) |=> cpu_halt && !cpu_clk_on)
        else $error("cpu not halted in sleep");

    chk_wake_delay: assert property (@(posedge aclk) disable iff (!aresetn) // RL13
        (clk_en && state_reg == SLC_ASLEEP && wake_evt) |=> !cpu_resume [*6])
        else $error("resume before six cycles");

    chk_idle_resume: assert property (@(posedge aclk) disable iff (!aresetn) // RL14
        (state_reg == SLC_ASLEEP && mode_reg == SLC_MODE_IDLE && wake_evt && clk_en
         && bod_active_mode_field != SLC_BOD_WAIT_MODE) ##1 clk_en [*6] |=> cpu_resume)
        else $error("idle wake not six cycles");

    chk_power_down_mode_sources: assert property (@(posedge aclk) disable iff (!aresetn) // RL11
        (clk_en && state_reg == SLC_ASLEEP && mode_reg == SLC_MODE_POWER_DOWN_MODE && !debug_break
         && !(|(irq_pending & wake_enable_reg & 9'h007))) |=> state_reg == SLC_ASLEEP)
        else $error("power down woke on bad source");

    chk_debug_wake: assert property (@(posedge aclk) disable iff (!aresetn) // RL5
        (clk_en && state_reg == SLC_ASLEEP && debug_break) |=> state_reg == SLC_WAKING)
        else $error("debug break did not wake");

    chk_bod_wait: assert property (@(posedge aclk) disable iff (!aresetn) // RL16
        (clk_en && bod_active_mode_field == SLC_BOD_WAIT_MODE && !bod_ready) |=> !cpu_resume)
        else $error("resume before bod ready");

    chk_power_down_mode_gates: assert property (@(posedge aclk) disable iff (!aresetn) // RL10
        (clk_en && pd) |=> !per_clk_on && !adc_clk_on && pit_clk_on && watchdog_clk_on)
        else $error("power down gating wrong");

endmodule : slc_sleep_controller

`default_nettype wire

/* tb/slc_osc_model.sv */
/*
  Main oscillator model standing in the clock controller's place.
  Assumes main_osc_on from the sleep controller requests the oscillator.
*/
`timescale 1ns/10ps
`default_nettype none

module slc_osc_model #(
    parameter int START_CYCLES = 12
) (
    // clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // oscillator request and status
    input  wire logic main_osc_on,
    output logic      osc_ready
);
    logic [7:0] start_cnt_reg;

    // a dropped request restarts the full start-up, as a real oscillator would
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !main_osc_on)
        begin
            start_cnt_reg <= 8'h00;
            osc_ready     <= 1'b0;
        end
        else
        begin
            if (start_cnt_reg < 8'(START_CYCLES))
                start_cnt_reg <= start_cnt_reg + 8'h01;
            osc_ready <= (start_cnt_reg == 8'(START_CYCLES));
        end
    end
endmodule : slc_osc_model

`default_nettype wire

/* tb/sleep_mode_controller_tb.sv */
/*
  Self-checking bench for the sleep controller: register access, sleep entry,
  clock gating per mode, wake sources and wake delay.
  Assumes slc_pkg and the oscillator model are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none

module sleep_mode_controller_tb;
    import slc_pkg::*;

    logic               aclk, aresetn, clk_en, sleep_instr, debug_break, osc_ready;
    logic [7:0]         s_axi_awaddr, s_axi_araddr;
    logic [31:0]        s_axi_wdata, s_axi_rdata;
    logic [3:0]         s_axi_wstrb;
    logic [1:0]         s_axi_bresp, s_axi_rresp, bod_active_mode_field, sleep_mode;
    logic               s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic               s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic               s_axi_rvalid, s_axi_rready, cpu_halt, cpu_resume;
    logic [SLC_WK_N-1:0] irq_pending;
    logic               bod_ready, bod_uses_ulp, watchdog_uses_ulp, cpu_clk_on, per_clk_on;
    logic               rtc_clk_on, adc_clk_on, pit_clk_on, watchdog_clk_on, main_osc_on;
    logic               rtc_osc_on, ulp_osc_on, uart_on;
    int                 mismatches, total_checks;

    slc_sleep_controller dut_u (
        .aclk, .aresetn, .clk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sleep_instr,
        .debug_break, .cpu_halt, .cpu_resume, .irq_pending, .osc_ready,
        .bod_active_mode_field, .bod_ready, .bod_uses_ulp, .watchdog_uses_ulp,
        .cpu_clk_on, .per_clk_on, .rtc_clk_on, .adc_clk_on, .pit_clk_on,
        .watchdog_clk_on, .main_osc_on, .rtc_osc_on, .ulp_osc_on, .uart_on, .sleep_mode
    );

    slc_osc_model osc_u (.aclk, .aresetn, .main_osc_on, .osc_ready);

    initial
    begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic results();
        if (mismatches == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : results

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int k = 0; k < 50; k++)
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        s_axi_bready <= 1'b0;
        chk(32'(s_axi_bresp), 32'(er));
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
        for (int k = 0; k < 50; k++)
        begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, ed);
        chk(32'(s_axi_rresp), 32'(er));
    endtask : rd

    // program the control register, then run one sleep instruction
    task automatic go(input logic [31:0] ctrl);
        wr(SLC_SLEEP_CONTROL_OFS, ctrl, SLC_RESP_OKAY);
        @(posedge aclk);
        sleep_instr <= 1'b1;
        @(posedge aclk);
        sleep_instr <= 1'b0;
        repeat (3) @(posedge aclk);
        #1;
    endtask : go

    // raise a source (9 = debug break); n is cycles to resume, 0 if none came
    task automatic wake(input int src, output int n);
        n = 0;
        @(posedge aclk);
        if (src == 9) debug_break <= 1'b1;
        else irq_pending[src] <= 1'b1;
        for (int k = 1; k <= 60 && n == 0; k++)
        begin
            @(posedge aclk);
            #1;
            if (cpu_resume === 1'b1) n = k;
        end
        @(posedge aclk);
        debug_break <= 1'b0;
        irq_pending <= '0;
    endtask : wake

    initial
    begin
        #40000;
        mismatches++;
        results();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        int n;
        mismatches = 0; total_checks = 0;
        aresetn = 1'b0; clk_en = 1'b1; sleep_instr = 1'b0; debug_break = 1'b0;
        s_axi_awaddr = 8'h00; s_axi_araddr = 8'h00; s_axi_wdata = 32'h0; s_axi_wstrb = 4'hF;
        s_axi_awvalid = 1'b0; s_axi_wvalid = 1'b0; s_axi_bready = 1'b0;
        s_axi_arvalid = 1'b0; s_axi_rready = 1'b0; irq_pending = '0;
        bod_active_mode_field = 2'h0; bod_ready = 1'b1; bod_uses_ulp = 1'b0;
        watchdog_uses_ulp = 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        rd(SLC_SLEEP_CONTROL_OFS, 32'h0, SLC_RESP_OKAY);
        rd(SLC_STATUS_OFS, 32'h0, SLC_RESP_OKAY);
        rd(8'h10, 32'h0, SLC_RESP_SLVERR);
        wr(8'h10, 32'h1, SLC_RESP_SLVERR);
        chk({cpu_halt, cpu_clk_on, per_clk_on, main_osc_on}, 4'h7);
        go(32'hFF);
        chk(cpu_halt, 1'b0);
        rd(SLC_SLEEP_CONTROL_OFS, 32'h07, SLC_RESP_OKAY);
        go(32'h00);
        chk(cpu_halt, 1'b0);
        // idle: only the cpu clock stops, no oscillator wait
        wr(SLC_WAKE_ENABLE_OFS, 32'h1FF, SLC_RESP_OKAY);
        go(32'h01);
        chk({cpu_halt, cpu_clk_on, per_clk_on, rtc_clk_on, adc_clk_on, main_osc_on}, 6'h2F);
        rd(SLC_STATUS_OFS, 32'h1, SLC_RESP_OKAY);
        wake(SLC_WK_OTHER, n);
        chk(32'(n), 32'(SLC_WAKE_CYCLES + 1));
        // standby with no run_in_standby bit set
        go(32'h03);
        chk({rtc_clk_on, adc_clk_on, uart_on, main_osc_on, pit_clk_on, watchdog_clk_on}, 6'h03);
        wake(SLC_WK_OTHER, n);
        chk(32'(n), 32'h0);
        wake(SLC_WK_UART, n);
        chk(32'(n), 32'h0);
        wake(SLC_WK_TIMER_B, n);
        chk(32'(n > SLC_WAKE_CYCLES + 2), 32'h1);
        // standby with every run_in_standby bit set
        wr(SLC_RUN_STANDBY_OFS, 32'hF, SLC_RESP_OKAY);
        go(32'h03);
        chk({rtc_clk_on, adc_clk_on, uart_on, main_osc_on}, 4'hF);
        wake(SLC_WK_UART, n);
        chk(32'(n), 32'(SLC_WAKE_CYCLES + 1));
        // power down ignores run_in_standby
        watchdog_uses_ulp <= 1'b1;
        go(32'h05);
        chk({cpu_clk_on, per_clk_on, rtc_clk_on, adc_clk_on, main_osc_on, pit_clk_on,
             watchdog_clk_on, ulp_osc_on, rtc_osc_on, sleep_mode}, 11'h03E);
        wake(SLC_WK_TIMER_B, n);
        chk(32'(n), 32'h0);
        wake(SLC_WK_TWI, n);
        chk(32'(n > SLC_WAKE_CYCLES + 2), 32'h1);
        // nothing enabled: only a debug break wakes
        wr(SLC_WAKE_ENABLE_OFS, 32'h0, SLC_RESP_OKAY);
        go(32'h01);
        wake(SLC_WK_PIN, n);
        chk(32'(n), 32'h0);
        wake(9, n);
        chk(32'(n), 32'(SLC_WAKE_CYCLES + 1));
        // brownout detector late, then already ready
        wr(SLC_WAKE_ENABLE_OFS, 32'h1FF, SLC_RESP_OKAY);
        bod_active_mode_field <= 2'h3;
        bod_ready <= 1'b0;
        go(32'h01);
        fork
            begin
                repeat (20) @(posedge aclk);
                bod_ready <= 1'b1;
            end
        join_none
        wake(SLC_WK_PIN, n);
        chk(32'(n > 18 && n < 26), 32'h1);
        go(32'h01);
        wake(SLC_WK_PIN, n);
        chk(32'(n), 32'(SLC_WAKE_CYCLES + 1));
        // reset while asleep
        go(32'h01);
        chk(cpu_halt, 1'b1);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        #1;
        chk({cpu_halt, cpu_clk_on}, 2'h1);
        rd(SLC_SLEEP_CONTROL_OFS, 32'h0, SLC_RESP_OKAY);
        results();
    end
endmodule : sleep_mode_controller_tb

`default_nettype wire
